/* common/gpio_port_pkg.sv */
/*
 * Constants for the eight-pin general purpose port: register map, field
 * positions, sense codes, reset values and virtual port layout.
 * Assumes a single peripheral clock and a plain strobe register port.
 */
// How it works
// - Events come only from clocked logic; no asynchronous event path exists.
// - Edge events fire only after the new pin value was clocked in.
// - Level sense: low gives no event, high gives one every cycle.
// - Low level events need the invert bit, which feeds the sense logic.
// - Sense code picks the signal event; data event carries pin value, except with sense code 7 (buffer off), when it is zero.
// - Enabled peripheral override replaces direction, output or pin value.
// - Direction and output overrides are plain ports, never visible through registers; value override shows in the input register.
// - Peripheral clock or channel 0 event can be routed to a chosen pin.
// - A routed event stands on the pin exactly as long as it lasts.
// - One pin configuration write updates every pin set in the mask.
// - Four virtual slots alias port registers; writes act like real ones.
// - Output enable bit one makes the pin an output, zero an input.
// - Set strobe register sets enable bits; reads return output enable.
// - Clear strobe register clears enable bits; reads return output enable.
// - Flip strobe register inverts enable bits; reads return output enable.
// - Drive level sets pin high or low only while it is an output.
// - Set strobe register sets drive bits; reads return drive level.
// - Clear strobe register clears drive bits; reads return drive level.
// - Flip strobe register inverts drive bits; reads return drive level.
// - Input register shows pin level; disabled buffer means no sampling.
// - Input register and flop before it form a two-stage synchroniser.
// - Sense field: 0 both, 1 rise, 2 fall, 3 level, 7 buffer off.
// - Invert bit inverts both driven output and sampled input.
package gpio_port_pkg;
   localparam int PINS = 8;
   localparam int ADDR_W = 6;
   localparam int VSLOTS = 4;
   // Real port registers
   localparam logic [5:0] OFS_OE = 6'h00;
   localparam logic [5:0] OFS_OE_SET = 6'h01;
   localparam logic [5:0] OFS_OE_CLEAR = 6'h02;
   localparam logic [5:0] OFS_OE_FLIP = 6'h03;
   localparam logic [5:0] OFS_DRIVE = 6'h04;
   localparam logic [5:0] OFS_DRIVE_SET = 6'h05;
   localparam logic [5:0] OFS_DRIVE_CLEAR = 6'h06;
   localparam logic [5:0] OFS_DRIVE_FLIP = 6'h07;
   localparam logic [5:0] OFS_SAMPLE = 6'h08;
   localparam logic [5:0] OFS_PINCFG = 6'h10;
   localparam logic [5:0] OFS_MPC_MASK = 6'h18;
   localparam logic [5:0] OFS_ROUTE = 6'h19;
   localparam logic [5:0] OFS_VMAP = 6'h1C;
   localparam logic [5:0] OFS_VPORT = 6'h20;
   // Address groups of four (address bits 5:2) and of eight (bits 5:3)
   localparam logic [3:0] GRP_OE = 4'h0;
   localparam logic [3:0] GRP_DRIVE = 4'h1;
   localparam logic [3:0] GRP_VMAP = 4'h7;
   localparam logic [3:0] GRP_VPORT = 4'h8;
   localparam logic [2:0] GRP_PINCFG = 3'h2;
   // Strobe operations, taken from address bits 1:0
   localparam logic [1:0] OP_WRITE = 2'h0;
   localparam logic [1:0] OP_SET = 2'h1;
   localparam logic [1:0] OP_CLEAR = 2'h2;
   localparam logic [1:0] OP_FLIP = 2'h3;
   // Registers inside one virtual slot
   localparam logic [1:0] VSUB_OE = 2'h0;
   localparam logic [1:0] VSUB_DRIVE = 2'h1;
   localparam logic [1:0] VSUB_SAMPLE = 2'h2;
   // Pin configuration fields
   localparam int CFG_INV_BIT = 6;
   localparam int CFG_SENSE_LSB = 0;
   localparam logic [7:0] CFG_WMASK = 8'h7F;
   localparam logic [2:0] SENSE_BOTH = 3'h0;
   localparam logic [2:0] SENSE_RISE = 3'h1;
   localparam logic [2:0] SENSE_FALL = 3'h2;
   localparam logic [2:0] SENSE_LEVEL = 3'h3;
   localparam logic [2:0] SENSE_OFF = 3'h7;
   // Clock and event routing control fields
   localparam int ROUTE_PIN_LSB = 0;
   localparam int ROUTE_CLK_BIT = 3;
   localparam int ROUTE_EVT_BIT = 4;
   localparam logic [7:0] ROUTE_WMASK = 8'h1F;
   // Reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [3:0] VMAP_NONE = 4'hF;
endpackage

/* rtl/gpio_port.sv */
/*
 * Eight-pin general purpose port: direction and drive registers with
 * set, clear and flip strobes, synchronised pin sampling, per-pin sense
 * and invert, events, peripheral override, clock and event routing,
 * multi-pin configuration and four virtual register slots.
 * Assumes the register master follows the one-cycle strobe protocol, pin
 * inputs are asynchronous, and override and event inputs share CLOCK_I.
 */
// The plain strobed port was decided locally.
`timescale 1ns/100ps
module gpio_port #(
   parameter logic [3:0] PORT_NUM = 4'h0
) (
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire logic [gpio_port_pkg::ADDR_W-1:0] ADDR_I,
   input wire logic [7:0] WR_DATA_I,
   input wire logic WR_EN_I,
   input wire logic RD_EN_I,
   output logic [7:0] RD_DATA_O,
   input wire logic [gpio_port_pkg::PINS-1:0] PIN_I,
   output logic [gpio_port_pkg::PINS-1:0] PIN_OUT_O,
   output logic [gpio_port_pkg::PINS-1:0] PIN_OE_O,
   input wire logic [gpio_port_pkg::PINS-1:0] OVR_DIR_EN_I,
   input wire logic [gpio_port_pkg::PINS-1:0] OVR_DIR_I,
   input wire logic [gpio_port_pkg::PINS-1:0] OVR_OUT_EN_I,
   input wire logic [gpio_port_pkg::PINS-1:0] OVR_OUT_I,
   input wire logic [gpio_port_pkg::PINS-1:0] OVR_VAL_EN_I,
   input wire logic [gpio_port_pkg::PINS-1:0] OVR_VAL_I,
   input wire logic EVT_CH0_I,
   output logic [gpio_port_pkg::PINS-1:0] EVT_SIGNAL_O,
   output logic [gpio_port_pkg::PINS-1:0] EVT_DATA_O,
   output logic [gpio_port_pkg::PINS-1:0] CLK_ROUTE_O
);
   import gpio_port_pkg::*;

   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (!RST_N_I);

   // ************************************************************
   // Declarations and helpers
   // ************************************************************
   logic [7:0] oe_ff;
   logic [7:0] drive_ff;
   logic [7:0] pin_cfg_ff [PINS];
   logic [7:0] mpc_mask_ff;
   logic [7:0] route_ff;
   logic [3:0] vmap_ff [VSLOTS];
   logic [7:0] sync1_ff;
   logic [7:0] sync2_ff;
   logic [7:0] prev_ff;
   logic [7:0] rd_data_ff;
   logic [7:0] pin_out_ff;
   logic [7:0] pin_oe_ff;
   logic [7:0] evt_signal_ff;
   logic [7:0] evt_data_ff;
   logic [7:0] clk_route_ff;
   logic [7:0] value_eff;
   logic [7:0] nxt_evt_signal;
   logic [7:0] nxt_pin_out;
   logic [7:0] nxt_pin_oe;
   logic [7:0] nxt_clk_route;
   logic [7:0] rd_val;
   logic [VSLOTS-1:0] v_match;
   logic v_any;
   logic [1:0] v_sub;
   logic oe_wr;
   logic drive_wr;
   logic [1:0] oe_op;
   logic [1:0] drive_op;
   logic cfg_wr;
   logic [2:0] route_sel;

   // Shared by both strobe groups; zero bits keep the target bit in set, clear and flip
   function automatic logic [7:0] grp_update(input logic [7:0] cur,
                                            input logic [7:0] wd,
                                            input logic [1:0] op);
      logic [7:0] res;
      res = cur;
      case (op)
         OP_WRITE: res = wd;
         OP_SET: res = cur | wd;
         OP_CLEAR: res = cur & ~wd;
         default: res = cur ^ wd;
      endcase
      return res;
   endfunction

   // ************************************************************
   // Address decode, including the virtual slots
   // ************************************************************
   for (genvar k = 0; k < VSLOTS; k++) begin : g_vslot
      // A slot only answers when software has mapped it to this port
      assign v_match[k] = (vmap_ff[k] == PORT_NUM) && (ADDR_I[5:2] == (GRP_VPORT + 4'(k)));
   end
   assign v_any = |v_match;
   assign v_sub = ADDR_I[1:0];

   // Virtual writes land on the same update path as real ones
   assign oe_wr = WR_EN_I && ((ADDR_I[5:2] == GRP_OE) || (v_any && v_sub == VSUB_OE));
   assign drive_wr = WR_EN_I && ((ADDR_I[5:2] == GRP_DRIVE) || (v_any && v_sub == VSUB_DRIVE));
   assign oe_op = v_any ? OP_WRITE : ADDR_I[1:0];
   assign drive_op = v_any ? OP_WRITE : ADDR_I[1:0];
   assign cfg_wr = WR_EN_I && (ADDR_I[5:3] == GRP_PINCFG);
   assign route_sel = route_ff[ROUTE_PIN_LSB +: 3];

   // ************************************************************
   // Direction and drive level registers
   // ************************************************************
   // Output enable: plain write plus set, clear and flip strobes
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         oe_ff <= RESET_BYTE;
      end else if (oe_wr) begin
         oe_ff <= grp_update(oe_ff, WR_DATA_I, oe_op);
      end
   end

   // Drive level, same strobe scheme
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         drive_ff <= RESET_BYTE;
      end else if (drive_wr) begin
         drive_ff <= grp_update(drive_ff, WR_DATA_I, drive_op);
      end
   end

   property p_oe_set;
      WR_EN_I && ADDR_I == OFS_OE_SET |=> oe_ff == ($past(oe_ff) | $past(WR_DATA_I));
   endproperty
   a_oe_set: assert property (p_oe_set) else $error("oe set strobe wrong");

   property p_oe_clear;
      WR_EN_I && ADDR_I == OFS_OE_CLEAR |=> oe_ff == ($past(oe_ff) & ~$past(WR_DATA_I));
   endproperty
   a_oe_clear: assert property (p_oe_clear) else $error("oe clear strobe wrong");

   property p_drive_flip;
      WR_EN_I && ADDR_I == OFS_DRIVE_FLIP |=> drive_ff == ($past(drive_ff) ^ $past(WR_DATA_I));
   endproperty
   a_drive_flip: assert property (p_drive_flip) else $error("drive flip strobe wrong");

   property p_vport_write;
      WR_EN_I && v_match[0] && v_sub == VSUB_OE |=> oe_ff == $past(WR_DATA_I);
   endproperty
   a_vport_write: assert property (p_vport_write) else $error("virtual write missed");

   // ************************************************************
   // Pin configuration, multi-pin mask, routing and slot maps
   // ************************************************************
   // A masked write fans out to every selected pin, else only the addressed one
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         for (int i = 0; i < PINS; i++) begin
            pin_cfg_ff[i] <= RESET_BYTE;
         end
      end else if (cfg_wr) begin
         for (int i = 0; i < PINS; i++) begin
            if ((mpc_mask_ff != RESET_BYTE) ? mpc_mask_ff[i] : (ADDR_I[2:0] == 3'(i))) begin
               pin_cfg_ff[i] <= WR_DATA_I & CFG_WMASK;
            end
         end
      end
   end

   // Mask is spent by the write it steers, so a later write is single-pin again
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         mpc_mask_ff <= RESET_BYTE;
      end else if (WR_EN_I && ADDR_I == OFS_MPC_MASK) begin
         mpc_mask_ff <= WR_DATA_I;
      end else if (cfg_wr) begin
         mpc_mask_ff <= RESET_BYTE;
      end
   end

   property p_multi_pin;
      cfg_wr && mpc_mask_ff[1] |=> pin_cfg_ff[1] == ($past(WR_DATA_I) & CFG_WMASK);
   endproperty
   a_multi_pin: assert property (p_multi_pin) else $error("masked pin not configured");

   // Clock and event routing control
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         route_ff <= RESET_BYTE;
      end else if (WR_EN_I && ADDR_I == OFS_ROUTE) begin
         route_ff <= WR_DATA_I & ROUTE_WMASK;
      end
   end

   // Virtual slot maps; reset leaves every slot unmapped
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         for (int k = 0; k < VSLOTS; k++) begin
            vmap_ff[k] <= VMAP_NONE;
         end
      end else if (WR_EN_I && ADDR_I[5:2] == GRP_VMAP) begin
         vmap_ff[ADDR_I[1:0]] <= WR_DATA_I[3:0];
      end
   end

   // ************************************************************
   // Pin sampling
   // ************************************************************
   // Two-flop synchroniser; the second stage is the input register itself
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sync1_ff <= RESET_BYTE;
         sync2_ff <= RESET_BYTE;
      end else begin
         sync1_ff <= PIN_I;
         sync2_ff <= sync1_ff;
      end
   end

   sequence s_pin_steady;
      !OVR_VAL_EN_I[0] && pin_cfg_ff[0] == RESET_BYTE [*3];
   endsequence
   property p_sync_delay;
      s_pin_steady |-> value_eff[0] == $past(PIN_I[0], 2);
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("sample not two cycles behind pin");

   // ************************************************************
   // Per-pin sense, invert and drive
   // ************************************************************
   for (genvar p = 0; p < PINS; p++) begin : g_pin
      logic [2:0] sense;
      logic inv;
      logic out_bit;
      assign sense = pin_cfg_ff[p][CFG_SENSE_LSB +: 3];
      assign inv = pin_cfg_ff[p][CFG_INV_BIT];

      // Override wins; a disabled buffer is never sampled and reads zero
      always_comb begin
         if (OVR_VAL_EN_I[p]) begin
            value_eff[p] = OVR_VAL_I[p];
         end else if (sense == SENSE_OFF) begin
            value_eff[p] = 1'b0;
         end else begin
            value_eff[p] = sync2_ff[p] ^ inv;
         end
      end

      // Edges compare against the previous clocked value, so nothing fires unclocked
      always_comb begin
         case (sense)
            SENSE_BOTH: nxt_evt_signal[p] = value_eff[p] ^ prev_ff[p];
            SENSE_RISE: nxt_evt_signal[p] = value_eff[p] & ~prev_ff[p];
            SENSE_FALL: nxt_evt_signal[p] = ~value_eff[p] & prev_ff[p];
            SENSE_LEVEL: nxt_evt_signal[p] = value_eff[p];
            default: nxt_evt_signal[p] = 1'b0;
         endcase
      end

      // Drive path: override, invert, then routed event on the chosen pin
      assign out_bit = (OVR_OUT_EN_I[p] ? OVR_OUT_I[p] : drive_ff[p]) ^ inv;
      always_comb begin
         nxt_clk_route[p] = route_ff[ROUTE_CLK_BIT] && route_sel == 3'(p);
         if (route_ff[ROUTE_EVT_BIT] && route_sel == 3'(p)) begin
            nxt_pin_out[p] = EVT_CH0_I;
            nxt_pin_oe[p] = 1'b1;
         end else begin
            nxt_pin_out[p] = out_bit;
            nxt_pin_oe[p] = nxt_clk_route[p] | (OVR_DIR_EN_I[p] ? OVR_DIR_I[p] : oe_ff[p]);
         end
      end
   end

   // ************************************************************
   // Events
   // ************************************************************
   // Signal and data events are registered; no path bypasses the clock
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         prev_ff <= RESET_BYTE;
         evt_signal_ff <= RESET_BYTE;
         evt_data_ff <= RESET_BYTE;
      end else begin
         prev_ff <= value_eff;
         evt_signal_ff <= nxt_evt_signal;
         evt_data_ff <= value_eff;
      end
   end
   assign EVT_SIGNAL_O = evt_signal_ff;
   assign EVT_DATA_O = evt_data_ff;

   sequence s_rise0;
      pin_cfg_ff[0][2:0] == SENSE_RISE && value_eff[0] && !prev_ff[0];
   endsequence
   property p_rise_event;
      s_rise0 |=> EVT_SIGNAL_O[0];
   endproperty
   a_rise_event: assert property (p_rise_event) else $error("rising edge event missed");

   property p_level_high;
      pin_cfg_ff[0][2:0] == SENSE_LEVEL && value_eff[0] [*2] |=> EVT_SIGNAL_O[0] && $past(EVT_SIGNAL_O[0]);
   endproperty
   a_level_high: assert property (p_level_high) else $error("high level not repeating");

   property p_level_low;
      pin_cfg_ff[0][2:0] == SENSE_LEVEL && !value_eff[0] |=> !EVT_SIGNAL_O[0];
   endproperty
   a_level_low: assert property (p_level_low) else $error("low level raised event");

   property p_data_event;
      1'b1 |=> EVT_DATA_O == $past(value_eff);
   endproperty
   a_data_event: assert property (p_data_event) else $error("data event not pin value");

   // ************************************************************
   // Pin drive outputs
   // ************************************************************
   // Registered so pads see no decode glitches; costs one cycle of latency
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pin_out_ff <= RESET_BYTE;
         pin_oe_ff <= RESET_BYTE;
         clk_route_ff <= RESET_BYTE;
      end else begin
         pin_out_ff <= nxt_pin_out;
         pin_oe_ff <= nxt_pin_oe;
         clk_route_ff <= nxt_clk_route;
      end
   end
   assign PIN_OUT_O = pin_out_ff;
   assign PIN_OE_O = pin_oe_ff;
   assign CLK_ROUTE_O = clk_route_ff;

   property p_direction;
      !OVR_DIR_EN_I[0] && !route_ff[ROUTE_CLK_BIT] && !route_ff[ROUTE_EVT_BIT] |=> PIN_OE_O[0] == $past(oe_ff[0]);
   endproperty
   a_direction: assert property (p_direction) else $error("pin direction not from enable");

   // Follows whichever pin is selected, so the check is live for any routing choice
   property p_event_route;
      route_ff[ROUTE_EVT_BIT] |=> PIN_OUT_O[$past(route_sel)] == $past(EVT_CH0_I) && PIN_OE_O[$past(route_sel)];
   endproperty
   a_event_route: assert property (p_event_route) else $error("routed event not on pin");

   // ************************************************************
   // Read path
   // ************************************************************
   // Strobe registers read back their target; unmapped addresses read zero
   always_comb begin
      rd_val = RESET_BYTE;
      if (ADDR_I[5:2] == GRP_OE) begin
         rd_val = oe_ff;
      end else if (ADDR_I[5:2] == GRP_DRIVE) begin
         rd_val = drive_ff;
      end else if (ADDR_I == OFS_SAMPLE) begin
         rd_val = value_eff;
      end else if (ADDR_I[5:3] == GRP_PINCFG) begin
         rd_val = pin_cfg_ff[ADDR_I[2:0]];
      end else if (ADDR_I == OFS_MPC_MASK) begin
         rd_val = mpc_mask_ff;
      end else if (ADDR_I == OFS_ROUTE) begin
         rd_val = route_ff;
      end else if (ADDR_I[5:2] == GRP_VMAP) begin
         rd_val = {4'h0, vmap_ff[ADDR_I[1:0]]};
      end else if (v_any) begin
         case (v_sub)
            VSUB_OE: rd_val = oe_ff;
            VSUB_DRIVE: rd_val = drive_ff;
            VSUB_SAMPLE: rd_val = value_eff;
            default: rd_val = RESET_BYTE;
         endcase
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rd_data_ff <= RESET_BYTE;
      end else begin
         rd_data_ff <= RD_EN_I ? rd_val : RESET_BYTE;
      end
   end
   assign RD_DATA_O = rd_data_ff;

   property p_read_oe_alias;
      RD_EN_I && ADDR_I == OFS_OE_FLIP |=> RD_DATA_O == $past(oe_ff);
   endproperty
   a_read_oe_alias: assert property (p_read_oe_alias) else $error("flip register read wrong");

   property p_buffer_off;
      RD_EN_I && ADDR_I == OFS_SAMPLE && pin_cfg_ff[1][2:0] == SENSE_OFF && !OVR_VAL_EN_I[1] |=> !RD_DATA_O[1];
   endproperty
   a_buffer_off: assert property (p_buffer_off) else $error("disabled pin was sampled");
endmodule

/* sim/pin_partner.sv */
/*
 * Model of the circuitry on the far side of the port pins.
 * Assumes the pad mux puts the clock on a routed pin and that the
 * bench commands the level of every pin the port does not drive.
 */
`timescale 1ns/100ps
module pin_partner (
   input wire logic clk_i,
   input wire logic [gpio_port_pkg::PINS-1:0] pin_out_i,
   input wire logic [gpio_port_pkg::PINS-1:0] pin_oe_i,
   input wire logic [gpio_port_pkg::PINS-1:0] clk_route_i,
   input wire logic [gpio_port_pkg::PINS-1:0] ext_level_i,
   output logic [gpio_port_pkg::PINS-1:0] pin_o
);
   import gpio_port_pkg::*;
   // ****************************************
   // Pad level seen back at the input buffer
   // ****************************************
   // A driven pin reads back its own level, so a wrong enable shows up as a wrong sample
   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         if (clk_route_i[i]) begin
            pin_o[i] = clk_i;
         end else if (pin_oe_i[i]) begin
            pin_o[i] = pin_out_i[i];
         end else begin
            pin_o[i] = ext_level_i[i];
         end
      end
   end
endmodule

/* sim/tb_top.sv */
/*
 * Self-checking bench for the eight-pin port: register strobes, sampling,
 * sense and events, multi-pin writes, virtual slots, routing and overrides.
 * Assumes the pin partner model stands on the pad side.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_top;
   import gpio_port_pkg::*;
   // ****************************************
   // Signals, design and partner
   // ****************************************
   localparam logic [3:0] PNUM = 4'h2;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, evt0 = 1'b0, rd_seen = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [7:0] wdat = 8'h00, ext = 8'h00, odir_en = 8'h00, odir = 8'h00, oout_en = 8'h00;
   logic [7:0] oout = 8'h00, oval_en = 8'h00, oval = 8'h00, oe_m = 8'h00, drv_m = 8'h00, d, e_w;
   logic [7:0] rdat, pin_in, pin_out, pin_oe, ev_sig, ev_dat, clk_rt;
   logic [7:0] exp_q[$];
   int bad_count = 0, checks = 0, cnt;
   integer seed = 32'h290e;
   gpio_port #(.PORT_NUM(PNUM)) gpio_port_inst (.CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
      .WR_DATA_I(wdat), .WR_EN_I(wr), .RD_EN_I(rd), .RD_DATA_O(rdat), .PIN_I(pin_in), .PIN_OUT_O(pin_out),
      .PIN_OE_O(pin_oe), .OVR_DIR_EN_I(odir_en), .OVR_DIR_I(odir), .OVR_OUT_EN_I(oout_en), .OVR_OUT_I(oout),
      .OVR_VAL_EN_I(oval_en), .OVR_VAL_I(oval), .EVT_CH0_I(evt0), .EVT_SIGNAL_O(ev_sig),
      .EVT_DATA_O(ev_dat), .CLK_ROUTE_O(clk_rt));
   pin_partner pin_partner_inst (.clk_i(clk), .pin_out_i(pin_out), .pin_oe_i(pin_oe), .clk_route_i(clk_rt),
      .ext_level_i(ext), .pin_o(pin_in));
   always #5 clk = ~clk;
   // ****************************************
   // Bus tasks and reference model
   // ****************************************
   // Every call drives all strobes once, so back-to-back calls never double-assign
   task automatic bus(input logic w, input logic r, input logic [5:0] a, input logic [7:0] dd);
      wr <= w;
      rd <= r;
      addr <= a;
      wdat <= dd;
      @(posedge clk);
   endtask
   task automatic wrt(input logic [5:0] a, input logic [7:0] dd);
      bus(1'b1, 1'b0, a, dd);
   endtask
   task automatic rdx(input logic [5:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      bus(1'b0, 1'b1, a, 8'h00);
   endtask
   task automatic idle(input int n);
      repeat (n) bus(1'b0, 1'b0, 6'h00, 8'h00);
   endtask
   function automatic logic [7:0] apply(input logic [7:0] cur, input logic [1:0] op, input logic [7:0] v);
      case (op)
         OP_WRITE: return v;
         OP_SET: return cur | v;
         OP_CLEAR: return cur & ~v;
         default: return cur ^ v;
      endcase
   endfunction
   // Pulse pin 0 away from its base level for four cycles and count signal events
   task automatic ev_run(input logic [7:0] cfg, input logic base, input int e);
      wrt(6'h10, cfg);
      ext[0] <= base;
      idle(10);
      cnt = 0;
      for (int i = 0; i < 16; i++) begin
         ext[0] <= (i < 4) ? ~base : base;
         idle(1);
         if (ev_sig[0] === 1'b1) cnt++;
      end
      `CHK(cnt, e)
   endtask
   task automatic print_verdict();
      if (bad_count == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ****************************************
   // Read data watcher
   // ****************************************
   // Read data stand only in the cycle after the strobe, so the check is tied to it
   always @(posedge clk) begin
      if (rd_seen) begin
         e_w = exp_q.pop_front();
         `CHK(rdat, e_w)
      end
      rd_seen <= rd;
   end
   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdx(6'h00, 8'h00);
      rdx(6'h04, 8'h00);
      `CHK(pin_oe, 8'h00)
      for (int g = 0; g < 2; g++) begin
         for (int op = 0; op < 8; op++) begin
            d = 8'($random(seed));
            if (g == 0) oe_m = apply(oe_m, op[1:0], d);
            else drv_m = apply(drv_m, op[1:0], d);
            wrt({3'b000, g[0], op[1:0]}, d);
            rdx({3'b000, g[0], ~op[1:0]}, (g == 0) ? oe_m : drv_m);
         end
      end
      idle(3);
      `CHK(pin_oe, oe_m)
      `CHK(pin_in & oe_m, drv_m & oe_m)
      wrt(6'h00, 8'h00);
      d = 8'($random(seed));
      ext <= d;
      idle(3);
      rdx(6'h08, d);
      ev_run(8'h00, 1'b0, 2);
      ev_run(8'h01, 1'b0, 1);
      ev_run(8'h02, 1'b0, 1);
      ev_run(8'h03, 1'b0, 4);
      ev_run(8'h07, 1'b0, 0);
      ev_run(8'h05, 1'b0, 0);
      ev_run(8'h43, 1'b1, 4);
      ext <= 8'hFF;
      wrt(6'h18, 8'h06);
      wrt(6'h10, 8'h07);
      idle(3);
      rdx(6'h11, 8'h07);
      rdx(6'h12, 8'h07);
      rdx(6'h10, 8'h43);
      rdx(6'h08, 8'hF8);
      wrt(6'h1C, {4'h0, PNUM});
      wrt(6'h21, 8'h5A);
      wrt(6'h25, 8'hFF);
      rdx(6'h04, 8'h5A);
      rdx(6'h30, 8'h00);
      rdx(6'h22, 8'hF8);
      // Virtual direction write; pin 4 becomes an output until the clear below
      wrt(6'h20, 8'h10);
      rdx(6'h00, 8'h10);
      wrt(6'h04, 8'h00);
      wrt(6'h01, 8'h20);
      wrt(6'h19, 8'h15);
      evt0 <= 1'b1;
      idle(1);
      evt0 <= 1'b0;
      idle(1);
      `CHK(pin_out[5], 1'b1)
      idle(1);
      `CHK(pin_out[5], 1'b0)
      wrt(6'h19, 8'h0D);
      idle(3);
      `CHK(clk_rt, 8'h20)
      wrt(6'h19, 8'h00);
      wrt(6'h02, 8'h30);
      wrt(6'h05, 8'h08);
      ext <= 8'h00;
      odir_en <= 8'h08;
      odir <= 8'h08;
      oout_en <= 8'h08;
      oval_en <= 8'h08;
      oval <= 8'h08;
      idle(4);
      `CHK(pin_oe[3], 1'b1)
      `CHK(pin_out[3], 1'b0)
      rdx(6'h08, 8'h09);
      `CHK(ev_dat, 8'h09)
      rdx(6'h00, 8'h00);
      idle(3);
      print_verdict();
   end
   // Whole run takes well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      print_verdict();
   end
endmodule
